//--- shared/uag_pkg.sv
/*
  uag_pkg: constants and types for the upper address / gpio pin mux.
  assumes a 32-bit classic wishbone slave port, 200 MHz system clock.
*/
`default_nettype none
package uag_pkg;
  localparam int UAG_PINS = 6;
  // offsets are 32-bit word indices; byte address is four times it
  localparam logic [15:0] UAG_BOOT_IDX = 16'h1C34;
  localparam logic [15:0] UAG_SEL_IDX = 16'h1C30;
  localparam logic [15:0] UAG_BOOT_ADR = 16'h70D0;
  localparam logic [15:0] UAG_SEL_ADR = 16'h70C0;
  // select field positions: bit n picks gpio (1) or address line (n+15)
  localparam int UAG_ADDR20_POS = 5;
  localparam int UAG_ADDR15_POS = 0;
  localparam logic [5:0] UAG_SEL_RESET = 6'h3F;
  localparam logic [5:0] UAG_BOOT_RESET = 6'h00;
  localparam logic [3:0] UAG_BOOT_DELAY_CYC = 4'hA;
  localparam logic [31:0] UAG_UNMAPPED_DATA = 32'h00000000;

  typedef struct packed {
    logic [5:0] o;
    logic [5:0] oe;
  } uag_pad_out_t;

  typedef struct packed {
    logic [5:0] pin_select;
    logic [5:0] boot;
    logic [3:0] cnt;
    logic done;
    logic ack;
    logic [31:0] rdat;
  } uag_state_t;
endpackage
`default_nettype wire

//--- verilog/uag_pad_cell.sv
/*
  uag_pad_cell: one shared pin, address line or gpio.
  assumes the gpio block supplies direction and data for the pin.
*/
`timescale 1ns/10ps
`default_nettype none
module uag_pad_cell (
  // selection
  input wire logic pick_gpio_i,
  input wire logic gpio_allowed_i,
  // functional sources
  input wire logic addr_i,
  input wire logic gpio_oe_i,
  input wire logic gpio_do_i,
  output logic gpio_di_o,
  // pin
  input wire logic pad_i,
  output logic pad_o,
  output logic pad_oe_o
);
  always_comb begin
    if (pick_gpio_i) begin
      // address output is cut off the pin entirely
      pad_o = gpio_do_i;
      pad_oe_o = gpio_oe_i & gpio_allowed_i;
      gpio_di_o = pad_i;
    end else begin
      pad_o = addr_i;
      pad_oe_o = 1'b1;
      gpio_di_o = 1'b0;
    end
  end
endmodule
`default_nettype wire

//--- verilog/uag_pin_mux.sv
/*
  uag_pin_mux: select register, boot strap capture and six shared pins.
  assumes a classic wishbone master and pins synchronous to clk_i.
*/
`timescale 1ns/10ps
`default_nettype none
module uag_pin_mux
  import uag_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // external memory address lines 20..15
  input wire logic [5:0] ext_mem_addr_line_i,
  // gpio 26..21
  input wire logic [5:0] general_io_oe_i,
  input wire logic [5:0] general_io_do_i,
  output logic [5:0] general_io_di_o,
  // shared pins
  input wire logic [5:0] pad_i,
  output uag_pad_out_t pad_o,
  // state seen by the rest of the chip
  output logic [5:0] external_bus_select_o,
  output logic [5:0] boot_select_latch_o,
  output logic boot_captured_o
);
  uag_state_t state;
  uag_state_t next_state;
  logic [5:0] pad_level;
  logic [5:0] pad_enable;

  function automatic logic hits(input logic [15:0] adr,
                                input logic [15:0] base);
    hits = (adr[15:2] == base[15:2]);
  endfunction

  always_comb begin
    next_state = state;
    next_state.ack = 1'b0;
    // count edges after release; capture exactly once
    if (!state.done) begin
      next_state.cnt = state.cnt + 4'h1;
      if (state.cnt == UAG_BOOT_DELAY_CYC - 4'h1) begin
        next_state.boot = pad_i;
        next_state.done = 1'b1;
      end
    end
    // single-cycle ack, dropped the cycle after
    if (wb_cyc_i && wb_stb_i && !state.ack) begin
      next_state.ack = 1'b1;
      next_state.rdat = UAG_UNMAPPED_DATA;
      if (hits(wb_adr_i, UAG_SEL_ADR)) begin
        next_state.rdat = {26'h0, state.pin_select};
      end else if (hits(wb_adr_i, UAG_BOOT_ADR)) begin
        // read-only; writes are ignored
        next_state.rdat = {26'h0, state.boot};
      end
    end
    // write lands on the ack edge, while the master still holds it
    if (wb_cyc_i && wb_stb_i && wb_we_i && state.ack && wb_sel_i[0] &&
        hits(wb_adr_i, UAG_SEL_ADR)) begin
      next_state.pin_select = wb_dat_i[5:0];
    end
    if (rst_i) begin
      next_state.pin_select = UAG_SEL_RESET;
      next_state.boot = UAG_BOOT_RESET;
      next_state.cnt = 4'h0;
      next_state.done = 1'b0;
      next_state.ack = 1'b0;
      next_state.rdat = UAG_UNMAPPED_DATA;
    end
  end

  always_ff @(posedge clk_i) begin
    state <= next_state;
  end

  // gpio drive held off until the straps are taken
  for (genvar i = 0; i < UAG_PINS; i++) begin : g_pad
    uag_pad_cell u_cell (
      .pick_gpio_i(state.pin_select[i]),
      .gpio_allowed_i(state.done),
      .addr_i(ext_mem_addr_line_i[i]),
      .gpio_oe_i(general_io_oe_i[i]),
      .gpio_do_i(general_io_do_i[i]),
      .gpio_di_o(general_io_di_o[i]),
      .pad_i(pad_i[i]),
      .pad_o(pad_level[i]),
      .pad_oe_o(pad_enable[i])
    );
  end

  assign pad_o = {pad_level, pad_enable};
  assign wb_dat_o = state.rdat;
  assign wb_ack_o = state.ack;
  assign external_bus_select_o = state.pin_select;
  assign boot_select_latch_o = state.boot;
  assign boot_captured_o = state.done;
endmodule
`default_nettype wire

//--- bench/uag_pin_mux_checker.sv
/* pin mux checker; assumes bind onto uag_pin_mux, one clock */
`timescale 1ns/10ps
`default_nettype none
module uag_pin_mux_checker
  import uag_pkg::*;
(
  // clock, reset, bus
  input wire logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_ack_o,
  // pins and state
  input wire logic [5:0] ext_mem_addr_line_i, general_io_oe_i, pad_i,
  input wire logic [5:0] general_io_di_o, external_bus_select_o,
  input wire logic [5:0] boot_select_latch_o,
  input wire uag_pad_out_t pad_o,
  input wire logic boot_captured_o
);
  wire [5:0] s = external_bus_select_o;
  wire c = boot_captured_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  addr_route_a: assert property (
    (pad_o.o & ~s) == (ext_mem_addr_line_i & ~s)) else $error("bad route");
  addr_drive_a: assert property (
    (pad_o.oe | s) == 6'h3F) else $error("pin undriven");
  gpio_oe_a: assert property (
    (pad_o.oe & s) == (general_io_oe_i & s & {6{c}})) else $error("bad oe");
  gpio_in_a: assert property (
    general_io_di_o == (pad_i & s)) else $error("bad gpio in");
  capture_time_a: assert property (
    $fell(rst_i) |-> !c [*8] ##1 !c [*2] ##1 c) else $error("bad capture");
  boot_value_a: assert property (
    $rose(c) |-> boot_select_latch_o == $past(pad_i)) else $error("bad boot");
  ack_time_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("long ack");
  cover property (c);
  cover property (wb_ack_o);
  cover property (pad_o.oe == 6'h3F);
endmodule
bind uag_pin_mux uag_pin_mux_checker chk (.*);
`default_nettype wire

//--- bench/uag_strap_model.sv
/* board strap model; assumes undriven pins rest at the strap level */
`timescale 1ns/10ps
`default_nettype none
module uag_strap_model
  import uag_pkg::*;
#(
  parameter logic [5:0] STRAP = 6'h2D
) (
  // pins as the chip drives them
  input wire uag_pad_out_t pin_i,
  // level seen at the pins
  output logic [5:0] lvl_o
);
  // strap resistors win only where the chip lets go of the pin
  assign lvl_o = (pin_i.oe & pin_i.o) | (~pin_i.oe & STRAP);
endmodule
`default_nettype wire

//--- bench/test_upper_address_gpio_pin_mux.sv
/* pin mux bench; assumes uag_pin_mux and the strap model */
`timescale 1ns/10ps
`default_nettype none
module test_upper_address_gpio_pin_mux import uag_pkg::*;;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, boot_captured_o;
  logic [15:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  logic [5:0] ext_mem_addr_line_i, general_io_oe_i, general_io_do_i, s;
  logic [5:0] general_io_di_o, pad_i, external_bus_select_o;
  logic [5:0] boot_select_latch_o;
  uag_pad_out_t pad_o;
  int error_cnt, num_checks, cyc_n;
  // rows: select value, address lines
  logic [11:0] r [8] = '{12'hFBF, 12'hF6A, 12'hED5, 12'hDFF,
                         12'hBC0, 12'h7FF, 12'hFEA, 12'h015};
  uag_pin_mux uut (.*);
  uag_strap_model bd (.pin_i(pad_o), .lvl_o(pad_i));
  initial begin
    clk_i = 0;
    forever #2.5 clk_i = ~clk_i;
  end
  task automatic chk(input logic [31:0] g, e);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask
  // no wait bound here: the cycle ceiling below cuts a hang
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d,
                    input logic [3:0] m = 4'hF);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, m};
    {wb_adr_i, wb_dat_i} <= {a, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 2000) begin
      error_cnt++;
      final_report;
    end
  end
  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, ext_mem_addr_line_i} = '0;
    wb_sel_i = 4'h0;
    // gpio drive enables 0F, gpio data 03
    {rst_i, general_io_oe_i, general_io_do_i} = 13'h13C3;
    repeat (12) @(posedge clk_i);
    chk(pad_o, {6'h03, 6'h00});
    rst_i <= 0;
    repeat (12) @(posedge clk_i);
    chk({boot_captured_o, boot_select_latch_o}, 7'h6D);
    wb(0, UAG_SEL_ADR, 0);
    chk(q, 32'h3F);
    wb(1, UAG_BOOT_ADR, 32'h12);
    wb(0, UAG_BOOT_ADR, 0);
    chk(q, 32'h2D);
    wb(0, 16'h0100, 0);
    chk(q, UAG_UNMAPPED_DATA);
    for (int i = 0; i < 8; i++) begin
      s = r[i][11:6];
      @(posedge clk_i);
      ext_mem_addr_line_i <= r[i][5:0];
      wb(1, UAG_SEL_ADR, {26'h0, s});
      @(negedge clk_i);
      chk(pad_o, {r[i][5:0] & ~s | 6'h03 & s, ~s | 6'h0F & s});
      // driven gpio pins show data 03, the rest their straps
      chk(general_io_di_o, 6'h23 & s);
      chk(external_bus_select_o, s);
    end
    @(posedge clk_i);
    wb(1, UAG_SEL_ADR, 32'h3F, 4'hE);
    wb(0, UAG_SEL_ADR, 0);
    chk(q, 32'h00);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    wb(0, UAG_SEL_ADR, 0);
    chk(q, 32'h3F);
    repeat (12) @(posedge clk_i);
    chk({boot_captured_o, boot_select_latch_o}, 7'h6D);
    final_report;
  end
endmodule
`default_nettype wire
